// ==== snf_regs.svh ====
// register offsets, field positions and command codes of the serial nand feature bank
`ifndef SNF_REGS_SVH
`define SNF_REGS_SVH
`define SNF_ADDR_LOCK 8'ha0
`define SNF_ADDR_OPT 8'hb0
`define SNF_ADDR_STAT 8'hc0
`define SNF_ADDR_THR 8'h10
`define SNF_CMD_GETF 8'h0f
`define SNF_CMD_SETF 8'h1f
`define SNF_CMD_WREN 8'h06
`define SNF_CMD_WRDIS 8'h04
`define SNF_CMD_PROT 8'h2a
`define SNF_CMD_PEXEC 8'h10
`define SNF_CMD_ERASE 8'hd8
`define SNF_CMD_RST1 8'hff
`define SNF_CMD_RST2 8'hfe
`define SNF_LOCK_GUARD 7
`define SNF_LOCK_HI 5
`define SNF_LOCK_LO 3
`define SNF_LOCK_MASK 8'hb8
`define SNF_OPT_MASK 8'h57
`define SNF_LOCK_RST 3'h7
`define SNF_OPT_RST 8'h12
`define SNF_THR_MASK 8'hf0
`define SNF_THR_RST 8'h00
`define SNF_OPT_ID 6
`define SNF_OPT_ECC 4
`define SNF_OPT_PROT 2
`define SNF_OPT_FAST 1
`define SNF_OPT_HOLD 0
`define SNF_BIT_LAST 3'h7
`define SNF_LOCK_ALL 3'h7
`endif

// ==== snf_pkg.sv ====
// types of the serial nand feature bank
package snf_pkg;
    typedef enum logic [1:0] {
        SNF_ST_CMD = 2'b00,
        SNF_ST_ADDR = 2'b01,
        SNF_ST_DATA = 2'b10,
        SNF_ST_SKIP = 2'b11
    } snf_state_t;
    typedef struct packed {
        logic busy;
        logic prog_fail;
        logic erase_fail;
        logic [1:0] ecc_result;
    } snf_core_status_t;
    typedef struct packed {
        logic id_page_mode;
        logic ecc_on;
        logic permanent_protect_arm;
        logic fast_page_read_on;
        logic hold_disable;
        logic [2:0] lock_range;
    } snf_config_t;
endpackage

// ==== snf_feature_regs.sv ====
// feature and status register bank behind the serial command link
// Operation
// - write-protect low and guard set freeze guard and lock-range bits.
// - lock field 000 unlocks all, 111 locks all, 111 after power-on.
// - codes 001..110 lock top 1/64 up to top half.
// - option bit 6 selects id/parameter page reads, default off.
// - option bit 4 enables internal correction, default on.
// - option bit 2 arms protect-execute 2Ah, default off.
// - option bit 1 enables fast page read, default on.
// - option bit 0 disables hold when set, default 0.
// - correction result reports last page read in two bits.
// - correction threshold taken from bits 7:4 of address 10h.
// - status bit 3 flags failed program or protect.
// - status bit 2 flags failed erase.
// - write latch set by 06h, cleared by 04h, untouched by set-feature.
// - status bit 0 shows busy.
// - get-feature repeats the selected byte while host clocks.
// - busy and fail bits refreshed in every repeated byte.
// - fail bits hold until next accepted program, protect or erase command.
// - program, protect or erase on locked block reports fail when the latch is set and not busy; protect only when armed.
// - reserved bits read zero.
// - settings survive reset commands, default only at power-on.
// - get-feature then address byte, data shifts until select rises.
`timescale 1ns/100ps
`include "snf_regs.svh"
module snf_feature_regs (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic sclk_i,
    input wire logic csn_i,
    input wire logic mosi_i,
    input wire logic wpn_i,
    output logic miso_o,
    output logic miso_oen_o,
    input wire snf_pkg::snf_core_status_t core_i,
    input wire logic target_locked_i,
    output snf_pkg::snf_config_t config_o,
    output logic write_permit_latch_o,
    output logic [3:0] ecc_threshold_o,
    output logic [7:0] cmd_o,
    output logic cmd_valid_o,
    output logic cmd_fail_o
);
    import snf_pkg::*;
    logic [1:0] sclk_sync_reg, csn_sync_reg, mosi_sync_reg, wpn_sync_reg;
    logic sclk_last_reg;
    snf_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] cmd_reg;
    logic [7:0] faddr_reg;
    logic [7:0] out_reg;
    logic lock_guard_reg;
    logic [2:0] lock_range_reg;
    logic [7:0] opt_reg;
    logic [7:0] thr_reg;
    logic write_permit_latch_reg;
    logic program_failed_reg;
    logic erase_failed_reg;
    logic cmd_valid_reg;
    logic cmd_fail_reg;
    logic rise, fall, sel, byte_done;
    logic [7:0] rx_byte, read_byte, status_byte;
    logic wp_low;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_sync_reg <= 2'h0;
            csn_sync_reg <= 2'h3;
            mosi_sync_reg <= 2'h0;
            wpn_sync_reg <= 2'h3;
            sclk_last_reg <= 1'b0;
        end else begin
            // two stages, only bit 1 is read by the logic
            sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
            csn_sync_reg <= {csn_sync_reg[0], csn_i};
            mosi_sync_reg <= {mosi_sync_reg[0], mosi_i};
            wpn_sync_reg <= {wpn_sync_reg[0], wpn_i};
            sclk_last_reg <= sclk_sync_reg[1];
        end
    end
    assign rise = sclk_sync_reg[1] & ~sclk_last_reg;
    assign fall = ~sclk_sync_reg[1] & sclk_last_reg;
    assign sel = ~csn_sync_reg[1];
    assign wp_low = ~wpn_sync_reg[1];
    assign rx_byte = {shift_reg[6:0], mosi_sync_reg[1]};
    assign byte_done = sel & rise & (bit_cnt_reg == `SNF_BIT_LAST);
    // status refreshed from live core state on every byte
    assign status_byte = {2'h0, core_i.ecc_result, program_failed_reg, erase_failed_reg,
                          write_permit_latch_reg, core_i.busy};
    always_comb begin
        unique case (faddr_reg)
            `SNF_ADDR_LOCK: read_byte = {lock_guard_reg, 1'b0, lock_range_reg, 3'h0};
            `SNF_ADDR_OPT: read_byte = opt_reg & `SNF_OPT_MASK;
            `SNF_ADDR_STAT: read_byte = status_byte;
            `SNF_ADDR_THR: read_byte = thr_reg & `SNF_THR_MASK;
            default: read_byte = 8'h00;
        endcase
    end
    // serial framing: command, address, then data
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= SNF_ST_CMD;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            cmd_reg <= 8'h00;
            faddr_reg <= 8'h00;
        end else if (!sel) begin
            state_reg <= SNF_ST_CMD;
            bit_cnt_reg <= 3'h0;
        end else if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= rx_byte;
            if (byte_done) begin
                unique case (state_reg)
                    SNF_ST_CMD: begin
                        cmd_reg <= rx_byte;
                        if (rx_byte == `SNF_CMD_GETF || rx_byte == `SNF_CMD_SETF) begin
                            state_reg <= SNF_ST_ADDR;
                        end else begin
                            state_reg <= SNF_ST_SKIP;
                        end
                    end
                    SNF_ST_ADDR: begin
                        faddr_reg <= rx_byte;
                        state_reg <= SNF_ST_DATA;
                    end
                    SNF_ST_DATA: state_reg <= SNF_ST_DATA;
                    SNF_ST_SKIP: state_reg <= SNF_ST_SKIP;
                endcase
            end
        end
    end
    // output shifter reloads each byte so status tracks the core
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_reg <= 8'h00;
            miso_o <= 1'b0;
            miso_oen_o <= 1'b1;
        end else if (!sel) begin
            miso_oen_o <= 1'b1;
        end else if (fall && state_reg == SNF_ST_DATA && cmd_reg == `SNF_CMD_GETF) begin
            miso_oen_o <= 1'b0;
            if (bit_cnt_reg == 3'h0) begin
                miso_o <= read_byte[7];
                out_reg <= {read_byte[6:0], 1'b0};
            end else begin
                miso_o <= out_reg[7];
                out_reg <= {out_reg[6:0], 1'b0};
            end
        end
    end
    // settings: power-on defaults only, reset commands leave them alone
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_guard_reg <= 1'b0;
            lock_range_reg <= `SNF_LOCK_RST;
            opt_reg <= `SNF_OPT_RST;
            thr_reg <= `SNF_THR_RST;
        end else if (byte_done && state_reg == SNF_ST_DATA && cmd_reg == `SNF_CMD_SETF
                     && bit_cnt_reg == `SNF_BIT_LAST) begin
            unique case (faddr_reg)
                `SNF_ADDR_LOCK: begin
                    if (!(wp_low && lock_guard_reg)) begin
                        lock_guard_reg <= rx_byte[`SNF_LOCK_GUARD];
                        lock_range_reg <= rx_byte[`SNF_LOCK_HI:`SNF_LOCK_LO];
                    end
                end
                `SNF_ADDR_OPT: opt_reg <= rx_byte & `SNF_OPT_MASK;
                `SNF_ADDR_THR: thr_reg <= rx_byte & `SNF_THR_MASK;
                default: thr_reg <= thr_reg;
            endcase
        end
    end
    // latch and fail flags driven by single-byte commands
    logic cmd_taken, is_prog, is_erase, prot_ok;
    assign cmd_taken = byte_done && state_reg == SNF_ST_CMD;
    assign is_prog = rx_byte == `SNF_CMD_PEXEC || rx_byte == `SNF_CMD_PROT;
    assign is_erase = rx_byte == `SNF_CMD_ERASE;
    assign prot_ok = rx_byte != `SNF_CMD_PROT || opt_reg[`SNF_OPT_PROT];
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            write_permit_latch_reg <= 1'b0;
        end else if (cmd_taken && rx_byte == `SNF_CMD_WREN) begin
            write_permit_latch_reg <= 1'b1;
        end else if (cmd_taken && rx_byte == `SNF_CMD_WRDIS) begin
            write_permit_latch_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            program_failed_reg <= 1'b0;
            erase_failed_reg <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_fail_reg <= 1'b0;
        end else begin
            cmd_valid_reg <= 1'b0;
            cmd_fail_reg <= 1'b0;
            if (core_i.prog_fail) begin
                program_failed_reg <= 1'b1;
            end
            if (core_i.erase_fail) begin
                erase_failed_reg <= 1'b1;
            end
            if (cmd_taken && rx_byte != `SNF_CMD_GETF && !core_i.busy) begin
                cmd_valid_reg <= 1'b1;
                if ((is_prog || is_erase) && write_permit_latch_reg && prot_ok) begin
                    // locked target: array untouched, fail flagged
                    cmd_fail_reg <= target_locked_i;
                    // a hardware fail pulse in the same cycle still wins
                    program_failed_reg <= (is_prog & target_locked_i) | core_i.prog_fail;
                    erase_failed_reg <= (is_erase & target_locked_i) | core_i.erase_fail;
                end
            end
        end
    end
    assign config_o = '{id_page_mode: opt_reg[`SNF_OPT_ID], ecc_on: opt_reg[`SNF_OPT_ECC],
                        permanent_protect_arm: opt_reg[`SNF_OPT_PROT],
                        fast_page_read_on: opt_reg[`SNF_OPT_FAST],
                        hold_disable: opt_reg[`SNF_OPT_HOLD], lock_range: lock_range_reg};
    assign write_permit_latch_o = write_permit_latch_reg;
    assign ecc_threshold_o = thr_reg[7:4];
    assign cmd_o = cmd_reg;
    assign cmd_valid_o = cmd_valid_reg;
    assign cmd_fail_o = cmd_fail_reg;
    property p_wel_set;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        cmd_taken && rx_byte == `SNF_CMD_WREN |=> write_permit_latch_reg;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch not set");
    property p_wel_setf;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !(cmd_taken && (rx_byte == `SNF_CMD_WREN || rx_byte == `SNF_CMD_WRDIS))
        |=> $stable(write_permit_latch_reg);
    endproperty
    a_wel_setf: assert property (p_wel_setf) else $error("latch moved");
    property p_guard;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        wp_low && lock_guard_reg && !csn_sync_reg[1] |=> $stable(lock_range_reg) && lock_guard_reg;
    endproperty
    a_guard: assert property (p_guard) else $error("locked field changed");
    property p_rsvd;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (read_byte & ((faddr_reg == `SNF_ADDR_LOCK) ? ~`SNF_LOCK_MASK :
                      (faddr_reg == `SNF_ADDR_OPT) ? ~`SNF_OPT_MASK :
                      (faddr_reg == `SNF_ADDR_THR) ? ~`SNF_THR_MASK :
                      (faddr_reg == `SNF_ADDR_STAT) ? 8'hc0 : 8'hff)) == 8'h00
        && status_byte[7:6] == 2'h0 && (opt_reg & ~`SNF_OPT_MASK) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_busy;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        status_byte[0] == core_i.busy && status_byte[5:4] == core_i.ecc_result;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not shown");
    property p_pfail;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        core_i.prog_fail |=> program_failed_reg;
    endproperty
    a_pfail: assert property (p_pfail) else $error("program fail lost");
    property p_efail;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        core_i.erase_fail |=> erase_failed_reg;
    endproperty
    a_efail: assert property (p_efail) else $error("erase fail lost");
    property p_hold;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !cmd_taken && !core_i.prog_fail |=> program_failed_reg == $past(program_failed_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("fail cleared early");
    property p_ehold;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !cmd_taken && !core_i.erase_fail |=> erase_failed_reg == $past(erase_failed_reg);
    endproperty
    a_ehold: assert property (p_ehold) else $error("erase fail cleared early");
    property p_oen_idle;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !sel |=> miso_oen_o;
    endproperty
    a_oen_idle: assert property (p_oen_idle) else $error("data line driven while deselected");
    property p_fail_pair;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        cmd_fail_o |-> cmd_valid_o;
    endproperty
    a_fail_pair: assert property (p_fail_pair) else $error("fail pulse without command");
    property p_lock_fail;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        cmd_taken && is_erase && write_permit_latch_reg && target_locked_i && !core_i.busy
        |=> erase_failed_reg && cmd_fail_reg;
    endproperty
    a_lock_fail: assert property (p_lock_fail) else $error("locked erase not flagged");
    property p_prot_gate;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        cmd_taken && rx_byte == `SNF_CMD_PROT && !opt_reg[`SNF_OPT_PROT] && !core_i.prog_fail
        |=> $stable(program_failed_reg) && !cmd_fail_reg;
    endproperty
    a_prot_gate: assert property (p_prot_gate) else $error("unarmed protect acted");
    property p_wel_clr;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        cmd_taken && rx_byte == `SNF_CMD_WRDIS |=> !write_permit_latch_reg;
    endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");
    property p_opt_write;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        byte_done && state_reg == SNF_ST_DATA && cmd_reg == `SNF_CMD_SETF && faddr_reg == `SNF_ADDR_OPT
        |=> opt_reg == ($past(rx_byte) & `SNF_OPT_MASK);
    endproperty
    a_opt_write: assert property (p_opt_write) else $error("option write lost");
endmodule

// ==== snf_host_model.sv ====
// host-side serial command model for the feature bank
`timescale 1ns/100ps
module snf_host_model (
    input wire logic clk_i,
    input wire logic miso_i,
    input wire logic miso_oen_i,
    output logic sclk_o,
    output logic csn_o,
    output logic mosi_o
);
    event byte_done;
    initial begin
        sclk_o = 1'b0;
        csn_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask
    // msb first, device data taken on the rise; undriven line reads inverted
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = d[i];
            half();
            sclk_o = 1'b1;
            q[i] = miso_oen_i ? ~miso_i : miso_i;
            half();
            sclk_o = 1'b0;
        end
        -> byte_done;
    endtask
    // n < 0: command only; q0 first and q1 last data byte seen
    task automatic frame(input logic [7:0] c, input logic [7:0] a, input int n, input logic [7:0] d,
                         output logic [7:0] q0, output logic [7:0] q1);
        logic [7:0] t;
        csn_o = 1'b0;
        half();
        xfer(c, t);
        if (n >= 0)
            xfer(a, t);
        for (int k = 0; k < n; k++) begin
            xfer(d, q1);
            if (k == 0)
                q0 = q1;
        end
        half();
        csn_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (8) @(negedge clk_i);
    endtask
endmodule

// ==== test_snf_feature_regs.sv ====
// self-checking bench of the feature register bank
`timescale 1ns/100ps
`include "snf_regs.svh"
module test_snf_feature_regs;
    import snf_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wpn_i = 1'b1;
    logic tgt = 1'b0;
    logic sclk, csn, mosi, miso, oen, write_permit_latch, fail, vld;
    int fail_pulses = 0;
    int valid_pulses = 0;
    snf_core_status_t core = '0;
    snf_config_t cfg;
    logic [3:0] thr;
    logic [7:0] cmd, q, q0;
    int fail_count = 0;
    int num_checks = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    snf_feature_regs i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk_i(sclk), .csn_i(csn),
        .mosi_i(mosi), .wpn_i(wpn_i), .miso_o(miso), .miso_oen_o(oen), .core_i(core),
        .target_locked_i(tgt), .config_o(cfg), .write_permit_latch_o(write_permit_latch),
        .ecc_threshold_o(thr), .cmd_o(cmd), .cmd_valid_o(vld), .cmd_fail_o(fail));
    snf_host_model host (.clk_i(clk_sys_i), .miso_i(miso), .miso_oen_i(oen), .sclk_o(sclk),
        .csn_o(csn), .mosi_o(mosi));
    // one-cycle pulses counted here, scenarios compare the counts
    always @(posedge clk_sys_i) begin
        if (fail === 1'b1)
            fail_pulses++;
        if (vld === 1'b1)
            valid_pulses++;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic getf(input logic [7:0] a, output logic [7:0] r);
        logic [7:0] z;
        host.frame(`SNF_CMD_GETF, a, 1, 8'h00, z, r);
    endtask
    task automatic setf(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] z;
        host.frame(`SNF_CMD_SETF, a, 1, d, z, z);
    endtask
    task automatic cmd1(input logic [7:0] c);
        logic [7:0] z;
        host.frame(c, 8'h00, -1, 8'h00, z, z);
    endtask
    task automatic t_defaults();
        getf(`SNF_ADDR_LOCK, q); check("lock", q, 8'h38);
        getf(`SNF_ADDR_OPT, q); check("opt", q, 8'h12);
        check("cfg", cfg, 8'h57);
        getf(`SNF_ADDR_STAT, q); check("stat", q, 8'h00);
    endtask
    task automatic t_options();
        setf(`SNF_ADDR_OPT, 8'hff);
        getf(`SNF_ADDR_OPT, q); check("opt", q, 8'h57);
        check("cfg", cfg, 8'hff);
        setf(`SNF_ADDR_OPT, 8'h01);
        check("cfg", cfg, 8'h0f);
        cmd1(8'h32);
        check("cmd", cmd, 8'h32);
        setf(`SNF_ADDR_OPT, 8'h12);
    endtask
    task automatic t_lock();
        for (int c = 0; c < 8; c++) begin
            setf(`SNF_ADDR_LOCK, {2'b01, c[2:0], 3'b111});
            getf(`SNF_ADDR_LOCK, q); check("lock", q, {2'b00, c[2:0], 3'b000});
            check("range", {5'h00, cfg.lock_range}, c[7:0]);
        end
    endtask
    task automatic t_guard();
        setf(`SNF_ADDR_LOCK, 8'h80);
        wpn_i = 1'b0;
        setf(`SNF_ADDR_LOCK, 8'h38);
        getf(`SNF_ADDR_LOCK, q); check("guarded", q, 8'h80);
        wpn_i = 1'b1;
        setf(`SNF_ADDR_LOCK, 8'h38);
        getf(`SNF_ADDR_LOCK, q); check("unguarded", q, 8'h38);
    endtask
    task automatic t_latch();
        cmd1(`SNF_CMD_WREN);
        getf(`SNF_ADDR_STAT, q); check("latch", q, 8'h02);
        check("wel", {7'h00, write_permit_latch}, 8'h01);
        setf(`SNF_ADDR_STAT, 8'h00);
        getf(`SNF_ADDR_STAT, q); check("latch", q, 8'h02);
        cmd1(`SNF_CMD_WRDIS);
        getf(`SNF_ADDR_STAT, q); check("latch", q, 8'h00);
        check("wel", {7'h00, write_permit_latch}, 8'h00);
    endtask
    task automatic t_status();
        int v0;
        for (int e = 0; e < 4; e++) begin
            core.ecc_result = e[1:0];
            getf(`SNF_ADDR_STAT, q); check("ecc", q, {2'b00, e[1:0], 4'h0});
        end
        core.ecc_result = 2'b00;
        core.busy = 1'b1;
        v0 = valid_pulses;
        cmd1(`SNF_CMD_WRDIS);
        check("busy_cmd", 8'(valid_pulses - v0), 8'h00);
        fork
            host.frame(`SNF_CMD_GETF, `SNF_ADDR_STAT, 2, 8'h00, q0, q);
            begin
                @(host.byte_done);
                @(host.byte_done);
                repeat (32) @(negedge clk_sys_i);
                core.busy = 1'b0;
            end
        join
        check("busy", q0, 8'h01);
        check("ready", q, 8'h00);
    endtask
    task automatic t_fail();
        int f0, v0;
        f0 = fail_pulses;
        v0 = valid_pulses;
        cmd1(`SNF_CMD_WREN);
        tgt = 1'b1;
        cmd1(`SNF_CMD_ERASE);
        tgt = 1'b0;
        check("fail_pulse", 8'(fail_pulses - f0), 8'h01);
        check("valid_pulse", 8'(valid_pulses - v0), 8'h02);
        getf(`SNF_ADDR_STAT, q); check("erase", q & 8'h0c, 8'h04);
        @(negedge clk_sys_i) core.prog_fail = 1'b1;
        @(negedge clk_sys_i) core.prog_fail = 1'b0;
        getf(`SNF_ADDR_STAT, q); check("prog", q & 8'h0c, 8'h0c);
        cmd1(`SNF_CMD_WREN);
        cmd1(`SNF_CMD_ERASE);
        getf(`SNF_ADDR_STAT, q); check("clear", q & 8'h0c, 8'h00);
        tgt = 1'b1;
        cmd1(`SNF_CMD_PROT);
        getf(`SNF_ADDR_STAT, q); check("unarmed", q & 8'h0c, 8'h00);
        setf(`SNF_ADDR_OPT, 8'h16);
        cmd1(`SNF_CMD_WREN);
        cmd1(`SNF_CMD_PROT);
        getf(`SNF_ADDR_STAT, q); check("protect", q & 8'h0c, 8'h08);
        cmd1(`SNF_CMD_ERASE);
        getf(`SNF_ADDR_STAT, q); check("erase_lock", q & 8'h0c, 8'h04);
        cmd1(`SNF_CMD_PEXEC);
        getf(`SNF_ADDR_STAT, q); check("program", q & 8'h0c, 8'h08);
        tgt = 1'b0;
        setf(`SNF_ADDR_OPT, 8'h12);
    endtask
    task automatic t_misc();
        setf(`SNF_ADDR_THR, 8'ha5);
        getf(`SNF_ADDR_THR, q); check("thr", q, 8'ha0);
        check("thr_out", {4'h0, thr}, 8'h0a);
        getf(8'h20, q); check("unknown", q, 8'h00);
        setf(`SNF_ADDR_OPT, 8'h03);
        cmd1(`SNF_CMD_RST1);
        cmd1(`SNF_CMD_RST2);
        getf(`SNF_ADDR_OPT, q); check("persist", q, 8'h03);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk_sys_i);
        fail_count++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rstn_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        t_defaults();
        t_options();
        t_lock();
        t_guard();
        t_latch();
        t_status();
        t_fail();
        t_misc();
        results();
    end
endmodule
